// ==== include/rlcc_pkg.sv ====
/*
 Shared constants and types for the re-driver lane configuration control block.
 Assumes a 125 MHz system clock and the register byte map of this device.
*/
package rlcc_pkg;
  localparam int NUM_CH = 8;
  localparam int LANES  = 4;

  localparam int SYS_CLK_PERIOD_NS  = 8;
  localparam int DETECT_TIMEOUT_NS  = 1000;
  localparam int DETECT_TIMEOUT_CYC =
    (DETECT_TIMEOUT_NS + SYS_CLK_PERIOD_NS - 1) / SYS_CLK_PERIOD_NS;
  localparam int TMO_W = 16;

  localparam logic [3:0] IDX_SIG    = 4'h0;
  localparam logic [3:0] IDX_RX     = 4'h1;
  localparam logic [3:0] IDX_LOOPBACK_EMPHASIS_CTRL   = 4'h2;
  localparam logic [3:0] IDX_CHANNEL_INPUT_DISABLE  = 4'h3;
  localparam logic [3:0] IDX_CHANNEL_OUTPUT_DISABLE = 4'h4;
  localparam logic [3:0] IDX_RESET  = 4'h5;
  localparam logic [3:0] IDX_PWR    = 4'h6;
  localparam logic [3:0] IDX_RECEIVER_DETECT_ENABLE   = 4'h7;
  localparam logic [3:0] IDX_GRPA   = 4'h8;
  localparam logic [3:0] IDX_GRPB   = 4'h9;
  localparam logic [3:0] IDX_RSVD   = 4'ha;
  localparam logic [3:0] IDX_MAX    = 4'hf;

  localparam logic [7:0] LOOPBACK_EMPHASIS_CTRL_RW_MASK = 8'hfc;
  localparam logic [1:0] LOOPBACK_EMPHASIS_CTRL_RSVD    = 2'h0;
  localparam logic [7:0] DIS_RST      = 8'h00;
  localparam logic [7:0] RSVD_VAL     = 8'h00;

  localparam logic [3:0] I2C_ACK_BIT = 4'h8;
  localparam logic [1:0] ADDR_TOP    = 2'h3;
  localparam logic [1:0] ADDR_GAP    = 2'h0;
  localparam logic [1:0] STRAP_SETTLE = 2'h3;

  typedef enum logic [1:0] {DET_IDLE, DET_WAIT, DET_DONE} rlcc_det_t;
  typedef enum logic [2:0] {ST_ADDR, ST_DUMMY, ST_WRITE, ST_READ, ST_IGNORE} rlcc_i2c_t;

  // Group byte: bit7..5 equalizer code bits 0..2, bit4..2 emphasis bits 0..2, bit1..0 swing 0..1.
  function automatic logic [7:0] grp_pack(input logic [2:0] eq, input logic [2:0] em,
                                          input logic [1:0] sw);
    return {eq[0], eq[1], eq[2], em[0], em[1], em[2], sw[0], sw[1]};
  endfunction
  function automatic logic [2:0] grp_eq(input logic [7:0] b);
    return {b[5], b[6], b[7]};
  endfunction
  function automatic logic [2:0] grp_em(input logic [7:0] b);
    return {b[2], b[3], b[4]};
  endfunction
  function automatic logic [1:0] grp_sw(input logic [7:0] b);
    return {b[0], b[1]};
  endfunction
endpackage

// ==== verilog/rlcc_top.sv ====
/*
 Lane configuration and control for an eight-channel, four-lane re-driver:
 strap latching, serial register port, receiver detect and termination control.
 Assumes the serial clock pin clocks the register port logic and that strap and
 address pins are static after power-up.
*/
// Operation
// [R1] Power-up copies each group's equalizer straps into its equalizer field.
// [R2] Serial writes change registers only while mode is low.
// [R3] One 3-bit equalizer code per group drives all four channels.
// [R4] Power-up copies swing and emphasis straps into each group's register.
// [R5] Two-bit swing field, high bit first, selects one of four levels. Code puts swing bit 0 first, in byte bit 1.
// [R6] Three-bit emphasis field selects one of eight emphasis magnitudes.
// [R7] Emphasis type powers up as de-emphasis; software may select pre-emphasis. Code loads the emphasis-type straps instead.
// [R8] Input below threshold turns the output driver off; legs pulled up.
// [R9] Receiver detect runs only with a card present; otherwise terminations off.
// [R10] Detect disabled: input terminated, output driven when signal valid, else pulled up.
// [R11] Low restart holds detect in its initial state; rising edge starts a cycle.
// [R12] Detect cycle pulls outputs up, waits, samples load, sets channel state.
// [R13] Chip power-down disables every channel with both terminations off.
// [R14] No card present disables every channel with both terminations off.
// [R15] Detect enabled without load: input off, output pulled up.
// [R16] Load detected: input terminated, output driven when valid, else pulled up.
// [R17] Restart low with power and card: input off, output pulled up.
// [R18] Loopback strap sets all lanes; each lane also has its own bit.
// [R19] The system picks loopback or normal once at initialisation.
// [R20] Register port is a 7-bit addressed serial slave with byte transfers.
// [R21] Bytes go from index zero upward; writes load until stop.
// [R22] Eleven byte registers: status, detect results, controls, two groups, reserved.
// [R23] Three address bits come from address straps.
// [R24] Slave address is 11, strap, 00, strap, strap, then read bit.
// [R25] First written byte is a dummy; transfers always start at index zero.
// [R26] A zero-to-one write of a restart bit starts a new detect cycle.
// [R27] Every received byte is acknowledged; the serial clock is never stretched.
// [R28] Detect wait is a counter of configurable length on the system clock.
// [R29] Dynamic control pins and detector outputs pass two-flop synchronisers.
`timescale 1ns/1ps
module rlcc_top
  import rlcc_pkg::*;
#(
  parameter int PROBE_TIMEOUT_CYC = DETECT_TIMEOUT_CYC
) (
  input  logic          sys_clk_in,
  input  logic          resetn_in,
  input  logic          scl_in,
  input  logic          sda_in,
  output logic          sda_out_out,
  output logic          sda_oe_n_out,
  input  logic          mode_in,
  input  logic          chip_sleep_n_in,
  input  logic          card_in_n_in,
  input  logic          probe_restart_a_n_in,
  input  logic          probe_restart_b_n_in,
  input  logic          probe_enable_a_in,
  input  logic          probe_enable_b_in,
  input  logic          loop_back_strap_n_in,
  input  logic          emph_type_a_in,
  input  logic          emph_type_b_in,
  input  logic [2:0]    eq_choice_group_a_in,
  input  logic [2:0]    eq_choice_group_b_in,
  input  logic [1:0]    swing_level_group_a_in,
  input  logic [1:0]    swing_level_group_b_in,
  input  logic [2:0]    emph_level_group_a_in,
  input  logic [2:0]    emph_level_group_b_in,
  input  logic          addr_strap_hi_in,
  input  logic          addr_strap_mid_in,
  input  logic          addr_strap_lo_in,
  input  logic [7:0]    level_det_in,
  input  logic [7:0]    load_sense_in,
  output logic [2:0]    eq_code_a_out,
  output logic [2:0]    eq_code_b_out,
  output logic [1:0]    swing_a_out,
  output logic [1:0]    swing_b_out,
  output logic [2:0]    emph_level_a_out,
  output logic [2:0]    emph_level_b_out,
  output logic          emph_type_a_out,
  output logic          emph_type_b_out,
  output logic [3:0]    loopback_n_out,
  output logic [7:0]    in_term_on_out,
  output logic [7:0]    out_drive_on_out,
  output logic [7:0]    out_pullup_on_out,
  output logic [7:0]    probe_on_out,
  output logic          input_level_valid_a_out,
  output logic          input_level_valid_b_out,
  output logic          far_load_found_a_out,
  output logic          far_load_found_b_out
);
  localparam int PIN_W = 44;

  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] pin_meta_r;
  logic [PIN_W-1:0] pin_sync_r;
  logic             scl_s, sda_s, mode_s, sleep_s, card_n_s;
  logic             rst_a_s, rst_b_s, rxd_a_s, rxd_b_s;
  logic [7:0]       lvl_s, load_s;
  logic [2:0]       st_eq_a, st_eq_b, st_em_a, st_em_b;
  logic [1:0]       st_sw_a, st_sw_b;
  logic             st_de_a, st_de_b, st_lb_n;
  logic             scl_d_r, sda_d_r, hold_r, pend_r;
  logic             bus_start, bus_stop, link_rst_n;
  logic [1:0]       init_cnt_r;
  logic             init_done_r, init_now;
  logic [1:0]       tgl_meta_r, tgl_sync_r, tgl_seen_r;
  logic             wr_evt, rd_evt;
  logic [7:0]       loopback_emphasis_ctrl_r, channel_input_disable_r, channel_output_disable_r, chrst_r, pwr_r, receiver_detect_enable_r, grp_a_r, grp_b_r;
  logic [7:0]       rd_byte_r;
  logic [7:0]       det_r, in_term_r, drive_r, pull_r, probe_r;
  rlcc_det_t        det_st_r [NUM_CH];
  logic [TMO_W-1:0] tmo_r [NUM_CH];
  // Serial clock domain.
  logic [2:0]       addr_meta_r, addr_sync_r;
  logic [7:0]       shreg_r;
  logic [3:0]       bit_cnt_r, ptr_r, wr_idx_r, rd_idx_r;
  logic [7:0]       wr_dat_r;
  logic             mack_r, ack_r, sda_oe_n_r, sda_lvl_r, wr_tgl_r, rd_tgl_r;
  rlcc_i2c_t        st_r;
  logic [6:0]       own_addr;
  logic             byte_end, addr_hit, fire_wr, fire_rd;

  assign pin_raw = {scl_in, sda_in, mode_in, chip_sleep_n_in, card_in_n_in,
                    probe_restart_a_n_in, probe_restart_b_n_in, probe_enable_a_in,
                    probe_enable_b_in, level_det_in, load_sense_in,
                    eq_choice_group_a_in, eq_choice_group_b_in, swing_level_group_a_in,
                    swing_level_group_b_in, emph_level_group_a_in, emph_level_group_b_in,
                    emph_type_a_in, emph_type_b_in, loop_back_strap_n_in};
  assign {scl_s, sda_s, mode_s, sleep_s, card_n_s, rst_a_s, rst_b_s, rxd_a_s, rxd_b_s,
          lvl_s, load_s, st_eq_a, st_eq_b, st_sw_a, st_sw_b, st_em_a, st_em_b,
          st_de_a, st_de_b, st_lb_n} = pin_sync_r;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pin_meta_r <= '0;
      pin_sync_r <= '0;
    end else begin
      pin_meta_r <= pin_raw;
      pin_sync_r <= pin_meta_r; // [R29]
    end
  end

  // Start and stop are seen on the system clock; the serial-clock logic is held in
  // reset from a stop until the first low phase of the clock after a start.
  assign bus_start  = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign bus_stop   = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign link_rst_n = resetn_in & ~hold_r;

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
      hold_r  <= 1'b1;
      pend_r  <= 1'b0;
    end else begin
      scl_d_r <= scl_s;
      sda_d_r <= sda_s;
      if (bus_start) begin
        hold_r <= 1'b1;
        pend_r <= 1'b1;
      end else if (bus_stop) begin
        hold_r <= 1'b1; // [R21]
        pend_r <= 1'b0;
      end else if (pend_r && !scl_s) begin
        hold_r <= 1'b0;
        pend_r <= 1'b0;
      end
    end
  end

  // Straps are caught once, after the synchronisers have filled.
  assign init_now = ~init_done_r & (init_cnt_r == STRAP_SETTLE);

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      init_cnt_r  <= '0;
      init_done_r <= 1'b0;
    end else if (!init_done_r) begin
      init_cnt_r  <= init_cnt_r + 2'h1;
      init_done_r <= init_now;
    end
  end

  // Event toggles from the serial domain; index and data stay still for a byte time.
  assign wr_evt = tgl_sync_r[1] ^ tgl_seen_r[1];
  assign rd_evt = tgl_sync_r[0] ^ tgl_seen_r[0];

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tgl_meta_r <= '0;
      tgl_sync_r <= '0;
      tgl_seen_r <= '0;
    end else begin
      tgl_meta_r <= {wr_tgl_r, rd_tgl_r};
      tgl_sync_r <= tgl_meta_r;
      tgl_seen_r <= tgl_sync_r;
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      loopback_emphasis_ctrl_r   <= '0;
      channel_input_disable_r  <= DIS_RST;
      channel_output_disable_r <= DIS_RST;
      chrst_r  <= '0;
      pwr_r    <= '0;
      receiver_detect_enable_r   <= '0;
      grp_a_r  <= '0;
      grp_b_r  <= '0;
    end else if (init_now) begin
      loopback_emphasis_ctrl_r   <= {{LANES{st_lb_n}}, st_de_a, st_de_b, LOOPBACK_EMPHASIS_CTRL_RSVD}; // [R18] [R7]
      channel_input_disable_r  <= DIS_RST;
      channel_output_disable_r <= DIS_RST;
      chrst_r  <= {LANES{rst_a_s, rst_b_s}};
      pwr_r    <= {NUM_CH{sleep_s}};
      receiver_detect_enable_r   <= {LANES{rxd_a_s, rxd_b_s}};
      grp_a_r  <= grp_pack(st_eq_a, st_em_a, st_sw_a); // [R1] [R4]
      grp_b_r  <= grp_pack(st_eq_b, st_em_b, st_sw_b); // [R1] [R4]
    end else if (wr_evt && init_done_r && !mode_s) begin // [R2]
      case (wr_idx_r) // [R22]
        IDX_LOOPBACK_EMPHASIS_CTRL:   loopback_emphasis_ctrl_r   <= wr_dat_r & LOOPBACK_EMPHASIS_CTRL_RW_MASK; // [R7]
        IDX_CHANNEL_INPUT_DISABLE:  channel_input_disable_r  <= wr_dat_r;
        IDX_CHANNEL_OUTPUT_DISABLE: channel_output_disable_r <= wr_dat_r;
        IDX_RESET:  chrst_r  <= wr_dat_r; // [R26]
        IDX_PWR:    pwr_r    <= wr_dat_r;
        IDX_RECEIVER_DETECT_ENABLE:   receiver_detect_enable_r   <= wr_dat_r;
        IDX_GRPA:   grp_a_r  <= wr_dat_r;
        IDX_GRPB:   grp_b_r  <= wr_dat_r;
        default:    ;
      endcase
    end
  end

  always_ff @(posedge sys_clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_byte_r <= '0;
    end else if (rd_evt) begin
      case (rd_idx_r) // [R22]
        IDX_SIG:    rd_byte_r <= lvl_s;
        IDX_RX:     rd_byte_r <= det_r;
        IDX_LOOPBACK_EMPHASIS_CTRL:   rd_byte_r <= loopback_emphasis_ctrl_r;
        IDX_CHANNEL_INPUT_DISABLE:  rd_byte_r <= channel_input_disable_r;
        IDX_CHANNEL_OUTPUT_DISABLE: rd_byte_r <= channel_output_disable_r;
        IDX_RESET:  rd_byte_r <= chrst_r;
        IDX_PWR:    rd_byte_r <= pwr_r;
        IDX_RECEIVER_DETECT_ENABLE:   rd_byte_r <= receiver_detect_enable_r;
        IDX_GRPA:   rd_byte_r <= grp_a_r;
        IDX_GRPB:   rd_byte_r <= grp_b_r;
        default:    rd_byte_r <= RSVD_VAL;
      endcase
    end
  end

  // Bit 7 is channel A0, bit 6 B0, down to bit 0 for B3: odd bits belong to group A.
  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    localparam bit IS_A = (i % 2) == 1;
    logic ch_hold;
    logic ch_on;

    assign ch_hold = ~(IS_A ? rst_a_s : rst_b_s) | ~chrst_r[i];
    assign ch_on   = init_done_r & sleep_s & ~card_n_s & pwr_r[i];

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        det_st_r[i] <= DET_IDLE;
        tmo_r[i]    <= '0;
        det_r[i]    <= 1'b0;
      end else if (!ch_on || ch_hold || !receiver_detect_enable_r[i]) begin // [R9] [R11]
        det_st_r[i] <= DET_IDLE;
        tmo_r[i]    <= '0;
        det_r[i]    <= 1'b0;
      end else begin
        case (det_st_r[i])
          DET_IDLE: begin
            det_st_r[i] <= DET_WAIT; // [R11] [R26]
            tmo_r[i]    <= TMO_W'(PROBE_TIMEOUT_CYC - 1); // [R28]
          end
          DET_WAIT: begin
            if (tmo_r[i] == '0) begin
              det_r[i]    <= load_s[i]; // [R12]
              det_st_r[i] <= DET_DONE;
            end else begin
              tmo_r[i] <= tmo_r[i] - 1'b1;
            end
          end
          DET_DONE: ;
          default:  det_st_r[i] <= DET_IDLE;
        endcase
      end
    end

    always_ff @(posedge sys_clk_in or negedge resetn_in) begin
      if (!resetn_in) begin
        in_term_r[i] <= 1'b0;
        drive_r[i]   <= 1'b0;
        pull_r[i]    <= 1'b0;
        probe_r[i]   <= 1'b0;
      end else begin
        probe_r[i] <= (det_st_r[i] == DET_WAIT) & ~channel_output_disable_r[i]; // [R12]
        if (!ch_on) begin // [R13] [R14]
          in_term_r[i] <= 1'b0;
          drive_r[i]   <= 1'b0;
          pull_r[i]    <= 1'b0;
        end else if (ch_hold) begin // [R17]
          in_term_r[i] <= 1'b0;
          drive_r[i]   <= 1'b0;
          pull_r[i]    <= ~channel_output_disable_r[i];
        end else if (!receiver_detect_enable_r[i] || (det_st_r[i] == DET_DONE && det_r[i])) begin // [R10] [R16]
          in_term_r[i] <= ~channel_input_disable_r[i];
          drive_r[i]   <= lvl_s[i] & ~channel_output_disable_r[i]; // [R8]
          pull_r[i]    <= ~lvl_s[i] & ~channel_output_disable_r[i];
        end else begin // [R15]
          in_term_r[i] <= 1'b0;
          drive_r[i]   <= 1'b0;
          pull_r[i]    <= ~channel_output_disable_r[i];
        end
      end
    end
  end

  assign eq_code_a_out           = grp_eq(grp_a_r); // [R3]
  assign eq_code_b_out           = grp_eq(grp_b_r); // [R3]
  assign swing_a_out             = grp_sw(grp_a_r); // [R5]
  assign swing_b_out             = grp_sw(grp_b_r); // [R5]
  assign emph_level_a_out        = grp_em(grp_a_r); // [R6]
  assign emph_level_b_out        = grp_em(grp_b_r); // [R6]
  assign emph_type_a_out         = loopback_emphasis_ctrl_r[3];
  assign emph_type_b_out         = loopback_emphasis_ctrl_r[2];
  assign loopback_n_out          = {loopback_emphasis_ctrl_r[4], loopback_emphasis_ctrl_r[5], loopback_emphasis_ctrl_r[6], loopback_emphasis_ctrl_r[7]}; // [R18]
  assign in_term_on_out          = in_term_r;
  assign out_drive_on_out        = drive_r;
  assign out_pullup_on_out       = pull_r;
  assign probe_on_out            = probe_r;
  assign input_level_valid_a_out = lvl_s[7];
  assign input_level_valid_b_out = lvl_s[6];
  assign far_load_found_a_out    = det_r[7];
  assign far_load_found_b_out    = det_r[6];
  assign sda_out_out             = sda_lvl_r;
  assign sda_oe_n_out            = sda_oe_n_r;

  // Serial register port. Bits are taken on the rising clock, SDA changes on the falling one.
  assign own_addr = {ADDR_TOP, addr_sync_r[2], ADDR_GAP, addr_sync_r[1:0]}; // [R23] [R24]
  assign byte_end = (bit_cnt_r == I2C_ACK_BIT);
  assign addr_hit = (shreg_r[7:1] == own_addr); // [R20]
  assign fire_wr  = byte_end & (st_r == ST_WRITE) & (ptr_r <= IDX_RSVD);
  assign fire_rd  = byte_end & ((st_r == ST_READ) | ((st_r == ST_ADDR) & addr_hit & shreg_r[0]));

  always_ff @(posedge scl_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      addr_meta_r <= '0;
      addr_sync_r <= '0;
      shreg_r     <= '0;
      bit_cnt_r   <= '0;
      mack_r      <= 1'b0;
    end else begin
      addr_meta_r <= {addr_strap_hi_in, addr_strap_mid_in, addr_strap_lo_in};
      addr_sync_r <= addr_meta_r;
      if (byte_end) begin
        bit_cnt_r <= '0;
        mack_r    <= sda_in;
      end else begin
        bit_cnt_r <= bit_cnt_r + 4'h1;
        shreg_r   <= {shreg_r[6:0], sda_in};
      end
    end
  end

  always_ff @(negedge scl_in or negedge link_rst_n) begin
    if (!link_rst_n) begin
      st_r       <= ST_ADDR;
      ptr_r      <= '0;
      ack_r      <= 1'b0;
      sda_oe_n_r <= 1'b1;
      sda_lvl_r  <= 1'b0;
    end else begin
      sda_lvl_r <= 1'b0;
      ack_r     <= 1'b0;
      if (byte_end) begin
        sda_oe_n_r <= 1'b1;
        case (st_r)
          ST_ADDR: begin
            ptr_r <= IDX_SIG; // [R25]
            if (addr_hit) begin
              sda_oe_n_r <= 1'b0; // [R27]
              ack_r      <= 1'b1;
              st_r       <= shreg_r[0] ? ST_READ : ST_DUMMY;
            end else begin
              st_r <= ST_IGNORE;
            end
          end
          ST_DUMMY: begin
            sda_oe_n_r <= 1'b0; // [R25] [R27]
            ack_r      <= 1'b1;
            st_r       <= ST_WRITE;
          end
          ST_WRITE: begin
            sda_oe_n_r <= 1'b0; // [R27]
            ack_r      <= 1'b1;
            if (ptr_r != IDX_MAX) begin
              ptr_r <= ptr_r + 4'h1; // [R21]
            end
          end
          ST_READ: begin
            if (ptr_r != IDX_MAX) begin
              ptr_r <= ptr_r + 4'h1; // [R21]
            end
          end
          default: ;
        endcase
      end else if (st_r == ST_READ) begin
        if (bit_cnt_r == '0 && mack_r) begin
          sda_oe_n_r <= 1'b1;
          st_r       <= ST_IGNORE;
        end else begin
          sda_oe_n_r <= rd_byte_r[~bit_cnt_r[2:0]];
        end
      end else begin
        sda_oe_n_r <= 1'b1;
      end
    end
  end

  // Toggles live outside the frame reset so that a new start never fakes an event.
  always_ff @(negedge scl_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_tgl_r <= 1'b0;
      rd_tgl_r <= 1'b0;
      wr_idx_r <= '0;
      wr_dat_r <= '0;
      rd_idx_r <= '0;
    end else begin
      if (fire_wr) begin
        wr_idx_r <= ptr_r; // [R21]
        wr_dat_r <= shreg_r;
        wr_tgl_r <= ~wr_tgl_r;
      end
      if (fire_rd) begin
        rd_idx_r <= (st_r == ST_ADDR) ? IDX_SIG : ptr_r + 4'h1; // [R25]
        rd_tgl_r <= ~rd_tgl_r;
      end
    end
  end

  property p_sleep_off;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      !sleep_s |=> (in_term_r == '0) && (drive_r == '0) && (pull_r == '0);
  endproperty
  a_sleep_off: assert property (p_sleep_off) else $error("Channel on in power-down."); // [R13]

  property p_no_card;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      sleep_s && card_n_s |=> (in_term_r == '0) && (drive_r == '0) && (pull_r == '0);
  endproperty
  a_no_card: assert property (p_no_card) else $error("Channel on without card."); // [R14]

  property p_restart_hold;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      init_done_r && sleep_s && !card_n_s && pwr_r[7] && !channel_output_disable_r[7] && !rst_a_s
      |=> pull_r[7] && !in_term_r[7] && det_st_r[7] == DET_IDLE;
  endproperty
  a_restart_hold: assert property (p_restart_hold) else $error("Restart not held."); // [R17]

  property p_probe_off;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      init_done_r && sleep_s && !card_n_s && pwr_r[7] && chrst_r[7] && rst_a_s
      && !receiver_detect_enable_r[7] && !channel_input_disable_r[7] |=> in_term_r[7];
  endproperty
  a_probe_off: assert property (p_probe_off) else $error("No input termination."); // [R10]

  logic ch_run6;
  assign ch_run6 = g_ch[6].ch_on & ~g_ch[6].ch_hold & receiver_detect_enable_r[6];
  property p_detect_done;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      det_st_r[6] == DET_WAIT && tmo_r[6] == '0 && ch_run6
      |=> det_st_r[6] == DET_DONE && det_r[6] == $past(load_s[6]);
  endproperty
  a_detect_done: assert property (p_detect_done) else $error("Detect result wrong."); // [R12]

  property p_mode_lock;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      init_done_r && mode_s |=> $stable(grp_a_r) && $stable(pwr_r) && $stable(loopback_emphasis_ctrl_r);
  endproperty
  a_mode_lock: assert property (p_mode_lock) else $error("Write while locked."); // [R2]

  property p_strap_load;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      init_now |=> grp_eq(grp_b_r) == $past(st_eq_b) && grp_sw(grp_b_r) == $past(st_sw_b)
      && grp_em(grp_b_r) == $past(st_em_b);
  endproperty
  a_strap_load: assert property (p_strap_load) else $error("Strap not latched."); // [R1]

  property p_squelch;
    @(posedge sys_clk_in) disable iff (!resetn_in)
      !lvl_s[7] |=> !drive_r[7];
  endproperty
  a_squelch: assert property (p_squelch) else $error("Driver on while idle."); // [R8]

  property p_ack;
    @(posedge scl_in) disable iff (!link_rst_n)
      ack_r |-> !sda_oe_n_r && bit_cnt_r == I2C_ACK_BIT;
  endproperty
  a_ack: assert property (p_ack) else $error("Acknowledge missing."); // [R27]
endmodule // rlcc_top

// ==== verification/rlcc_mst.sv ====
/*
 Serial bus master model that stands in front of the register port.
 Assumes the bench resolves the open-drain data wire with a pull-up.
*/
`timescale 1ns/1ps
module rlcc_mst (
  output logic      scl_out,
  output logic      sda_low_out,
  input  wire logic sda_in
);
  initial scl_out = 1'b1;
  initial sda_low_out = 1'b0;
  task automatic bit_io(input logic b, output logic r);
    sda_low_out = ~b;
    #12 scl_out = 1'b1;
    #12 r = sda_in;
    #12 scl_out = 1'b0;
    #12;
  endtask
  task automatic start();
    sda_low_out = 1'b0;
    #12 scl_out = 1'b1;
    #12 sda_low_out = 1'b1;
    #12 scl_out = 1'b0;
    // The port leaves frame reset only after it has seen this low phase.
    #36;
  endtask
  task automatic stop();
    sda_low_out = 1'b1;
    #12 scl_out = 1'b1;
    #12 sda_low_out = 1'b0;
    #24;
  endtask
  // Sends a byte, most significant bit first; m is the master's acknowledge level.
  task automatic xfer(input logic [7:0] d, input logic m, output logic [7:0] q, output logic a);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(m, a);
  endtask
endmodule // rlcc_mst

// ==== verification/tb_top.sv ====
/*
 Self-checking bench for the lane configuration block.
 Assumes the serial master model drives the register port.
*/
`timescale 1ns/1ps
module tb_top;
  logic sys_clk_in = 1'b0;
  logic resetn_in = 1'b0;
  logic mode = 1'b0;
  logic sleep_n = 1'b1;
  logic card_n = 1'b0;
  logic rs_n = 1'b1;
  logic [23:0] st = 24'hbc7b55;
  logic [7:0] lvl = 8'h3c;
  logic [7:0] load = 8'hf0;
  logic [7:0] wb [0:8] = '{8'h00, 8'h00, 8'h58, 8'h00, 8'h00, 8'hff, 8'hff, 8'hff, 8'h71};
  logic [7:0] rx;
  logic ack;
  int errors = 0;
  int num_checks = 0;
  wire logic scl;
  wire logic m_low;
  wire logic oe_n;
  wire logic sda = ~m_low & oe_n;
  wire logic [2:0] eqa, eqb, ema, emb;
  wire logic [1:0] swa, swb;
  wire logic eta, etb;
  wire logic [3:0] lb;
  wire logic [7:0] it, dr, pu, pr;
  wire logic fa, fb, va, vb, so;
  rlcc_mst u_rlcc_mst (.scl_out(scl), .sda_low_out(m_low), .sda_in(sda));
  rlcc_top #(.PROBE_TIMEOUT_CYC(4)) u_rlcc_top (
    .sys_clk_in(sys_clk_in), .resetn_in(resetn_in), .scl_in(scl), .sda_in(sda),
    .sda_out_out(so), .sda_oe_n_out(oe_n), .mode_in(mode), .chip_sleep_n_in(sleep_n),
    .card_in_n_in(card_n), .probe_restart_a_n_in(rs_n), .probe_restart_b_n_in(rs_n),
    .probe_enable_a_in(st[16]), .probe_enable_b_in(st[17]), .loop_back_strap_n_in(st[18]),
    .emph_type_a_in(st[19]), .emph_type_b_in(st[20]), .eq_choice_group_a_in(st[2:0]),
    .eq_choice_group_b_in(st[5:3]), .swing_level_group_a_in(st[7:6]),
    .swing_level_group_b_in(st[9:8]), .emph_level_group_a_in(st[12:10]),
    .emph_level_group_b_in(st[15:13]), .addr_strap_hi_in(st[21]),
    .addr_strap_mid_in(st[22]), .addr_strap_lo_in(st[23]), .level_det_in(lvl),
    .load_sense_in(load), .eq_code_a_out(eqa), .eq_code_b_out(eqb), .swing_a_out(swa),
    .swing_b_out(swb), .emph_level_a_out(ema), .emph_level_b_out(emb),
    .emph_type_a_out(eta), .emph_type_b_out(etb), .loopback_n_out(lb),
    .in_term_on_out(it), .out_drive_on_out(dr), .out_pullup_on_out(pu), .probe_on_out(pr),
    .input_level_valid_a_out(va), .input_level_valid_b_out(vb), .far_load_found_a_out(fa),
    .far_load_found_b_out(fb));
  always #4 sys_clk_in = ~sys_clk_in;
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      errors++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic wr();
    u_rlcc_mst.start();
    u_rlcc_mst.xfer(8'he2, 1'b1, rx, ack);
    chk(32'(ack), 32'h0);
    u_rlcc_mst.xfer(8'haa, 1'b1, rx, ack);
    for (int i = 0; i < 9; i++) begin
      u_rlcc_mst.xfer(wb[i], 1'b1, rx, ack);
    end
    u_rlcc_mst.stop();
    cyc(10);
  endtask
  task automatic t_reset();
    chk(32'({eqa, eqb, swa, swb, ema, emb, eta, etb, lb}), 32'h2a7cff);
    chk(32'({it, dr, pu}), 32'hff3cc3);
  endtask
  task automatic t_addr();
    u_rlcc_mst.start();
    u_rlcc_mst.xfer(8'he0, 1'b1, rx, ack);
    u_rlcc_mst.stop();
    chk(32'(ack), 32'h1);
  endtask
  task automatic t_write();
    wr();
    chk(32'({eqa, ema, swa, eta, etb, lb}), 32'h31aa);
  endtask
  task automatic t_lock();
    @(posedge sys_clk_in) mode <= 1'b1;
    wb[8] = 8'h00;
    wr();
    chk(32'({eqa, ema, swa}), 32'hc6);
    @(posedge sys_clk_in) mode <= 1'b0;
  endtask
  task automatic t_detect();
    @(posedge sys_clk_in) rs_n <= 1'b0;
    cyc(6);
    chk(32'({it, dr, pu}), 32'h0000ff);
    @(posedge sys_clk_in) rs_n <= 1'b1;
    cyc(5);
    chk(32'(pr), 32'hff);
    cyc(15);
    chk(32'({it, dr, pu}), 32'hf030cf);
    chk(32'({pr, fa, fb, va, vb, so}), 32'h18);
  endtask
  task automatic t_read();
    u_rlcc_mst.start();
    u_rlcc_mst.xfer(8'he3, 1'b1, rx, ack);
    chk(32'(ack), 32'h0);
    u_rlcc_mst.xfer(8'hff, 1'b0, rx, ack);
    chk(32'(rx), 32'h3c);
    u_rlcc_mst.xfer(8'hff, 1'b0, rx, ack);
    chk(32'(rx), 32'hf0);
    u_rlcc_mst.xfer(8'hff, 1'b1, rx, ack);
    chk(32'(rx), 32'h58);
    u_rlcc_mst.stop();
  endtask
  task automatic t_power();
    @(posedge sys_clk_in) sleep_n <= 1'b0;
    cyc(6);
    chk(32'({it, dr, pu}), 32'h0);
    @(posedge sys_clk_in) sleep_n <= 1'b1;
    card_n <= 1'b1;
    cyc(6);
    chk(32'({it, dr, pu}), 32'h0);
  endtask
  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge sys_clk_in);
    resetn_in <= 1'b1;
    cyc(12);
    t_reset();
    t_addr();
    t_write();
    t_lock();
    t_detect();
    t_read();
    t_power();
    final_report();
  end
  // Frames take at most about 5 us and the whole run about 13 us; a hang is cut off well beyond that.
  initial begin
    #100000;
    errors++;
    final_report();
  end
endmodule // tb_top
